// >>> hdl/adc_ctrl_pkg.sv
// shared constants and types for the converter control block
package adc_ctrl_pkg;
    localparam int CHANNELS = 8;
    localparam int CODE_W = 16;
    localparam int AVG_W = 20;

    // register indices on the plain register port
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_GENERAL = 4'h1;
    localparam logic [3:0] REG_AVERAGING = 4'h2;
    localparam logic [3:0] REG_TIMING = 4'h3;
    localparam logic [3:0] REG_PIN_MODE = 4'h4;
    localparam logic [3:0] REG_DIRECTION = 4'h5;
    localparam logic [3:0] REG_DRIVE_TYPE = 4'h6;
    localparam logic [3:0] REG_OUT_LEVELS = 4'h7;
    localparam logic [3:0] REG_IN_LEVELS = 4'h8;
    localparam logic [3:0] REG_SEQ_ENABLES = 4'h9;
    localparam logic [3:0] REG_SEQ_MODE = 4'ha;
    localparam logic [3:0] REG_CHANNEL = 4'hb;
    localparam logic [3:0] REG_START = 4'hc;
    localparam logic [3:0] REG_RESULT = 4'hd;

    // general settings field positions
    localparam int GEN_CAL_BIT = 1;
    localparam int GEN_REF_BIT = 7;
    localparam int GEN_RANGE_BIT = 0;
    // timing field positions
    localparam int TIM_DIV_LSB = 0;
    localparam int TIM_OSC_BIT = 4;
    // status bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    // reset values
    localparam logic [7:0] PIN_MODE_RST = 8'h00;
    localparam logic [7:0] SEQ_EN_RST = 8'h00;
    localparam logic [3:0] DIV_RST = 4'h0;

    // timing figures in ns, clock 40 ns
    localparam int CLK_NS = 40;
    localparam int CONV_NS = 3200;
    localparam int CAL_NS = 32000;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
    // step units: divider 0000b gives 32 us on the slow oscillator, 0100b 4 us on the fast one
    localparam int FAST_UNIT_NS = 1000;
    localparam int SLOW_UNIT_NS = 16000;
    localparam int FAST_UNIT_CYC = FAST_UNIT_NS / CLK_NS;
    localparam int SLOW_UNIT_CYC = SLOW_UNIT_NS / CLK_NS;

    typedef enum logic [1:0] {
        SEQ_MANUAL,
        SEQ_AUTO,
        SEQ_AUTONOMOUS
    } seq_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] outLevel;
        logic [7:0] outEnable;
        logic [7:0] analogSelect;
    } pin_drive_t;
endpackage : adc_ctrl_pkg

// >>> hdl/adc_channel_avg_control.sv
// digital control of an eight-channel converter with averaging filter
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - after reset every channel is an analog input.
// - each channel chooses analog or digital pin from its pin-mode bit.
// - digital channel direction follows its direction bit.
// - input-levels register returns sampled levels of digital inputs.
// - digital outputs drive the written output level.
// - each output is open-drain or push-pull by its drive-type bit.
// - after reset the external reference is selected.
// - internal reference is off until its enable bit is written one.
// - single-conversion results are straight binary, 0000 to ffff, saturating at top.
// - range bit resets to single-reference span; one doubles span.
// - writing the calibration bit while idle starts calibration; it self-clears.
// - three-bit averaging field enables filter and picks factor.
// - one averaging setting for all channels.
// - averaged result is 20 bits wide.
// - host starts only first conversion; device starts the rest.
// - averaging time follows rate and count; read after completion.
// - autonomous mode averages each enabled channel in turn.
// - internal clock times conversions; acquisition follows each one.
// - internal sample rate set by oscillator select and divider.
module adc_channel_avg_control (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // channel pins
    input  wire logic [7:0]  pinIn,
    output logic      [7:0]  pinOut,
    output logic      [7:0]  pinOe,
    output logic      [7:0]  analogSelect,
    // analog core
    output logic             convStart,
    output logic      [2:0]  convChannel,
    output logic             acquiring,
    output logic             calibrating,
    input  wire logic [15:0] convCode,
    output logic             internalRefOn,
    output logic             doubleSpan
);
    typedef enum logic [1:0] {
        IDLE,
        CONVERT,
        WAIT_NEXT,
        CALIBRATE
    } state_t;

    adc_ctrl_pkg::reg_req_t req;
    assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

    logic [1:0] rstSync_r;
    logic       rstn;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rstSync_r <= 2'b00;
        else         rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstn = rstSync_r[1];

    // software-visible settings
    logic [7:0] pinMode_r, direction_r, driveType_r, outLevels_r, seqEn_r, inLevels_r;
    logic       refEn_r, range_r, cal_r, oscSel_r, done_r;
    logic [2:0] avgFactor_r, manualCh_r;
    logic [3:0] clkDiv_r;
    logic [1:0] seqMode_r;
    logic [31:0] rdata_r;

    // conversion engine
    state_t     state_r;
    logic [15:0] phaseCnt_r;
    logic [7:0] sampleCnt_r;
    logic [23:0] accum_r;
    logic [19:0] result_r;
    logic [2:0] curCh_r;
    logic [31:0] waitCnt_r;

    function automatic logic [7:0] sample_count(input logic [2:0] f);
        sample_count = 8'h01 << f;
    endfunction : sample_count

    function automatic logic [2:0] next_enabled(input logic [2:0] ch, input logic [7:0] en);
        logic [2:0] c;
        c = ch;
        next_enabled = ch;
        for (int i = 1; i <= 8; i++) begin
            c = 3'(ch + 3'(i));
            if (en[c] && next_enabled == ch && i < 8) next_enabled = c;
        end
    endfunction : next_enabled

    // cycle time of internally started conversions
    wire logic [31:0] divMult = 32'h1 << clkDiv_r[3:1];
    wire logic [31:0] divBase = clkDiv_r[0] ? 32'd3 : 32'd2;
    wire logic [31:0] unitCyc = oscSel_r ? 32'(adc_ctrl_pkg::SLOW_UNIT_CYC)
                                         : 32'(adc_ctrl_pkg::FAST_UNIT_CYC);
    // 0100b fast: 2*4*1000ns/2 = 4 us, 250 kSPS; slow 0000b: 2*1*16 us = 32 us
    wire logic [31:0] cycleCyc = oscSel_r ? divBase * divMult * unitCyc
                                          : (divBase * divMult * unitCyc) >> 1;

    wire logic wrHit = req.wr;
    wire logic startReq = wrHit && req.addr == adc_ctrl_pkg::REG_START && req.wdata[0];
    wire logic calReq = wrHit && req.addr == adc_ctrl_pkg::REG_GENERAL
                        && req.wdata[adc_ctrl_pkg::GEN_CAL_BIT];
    wire logic avgOn = avgFactor_r != 3'h0;
    wire logic [7:0] needed = avgOn ? sample_count(avgFactor_r) : 8'h01;
    wire logic convEnd = state_r == CONVERT
                         && phaseCnt_r == 16'(adc_ctrl_pkg::CONV_CYC - 1);
    wire logic lastSample = sampleCnt_r + 8'h01 >= needed;
    wire logic autonomous = seqMode_r == 2'(adc_ctrl_pkg::SEQ_AUTONOMOUS);
    wire logic [23:0] accNext = accum_r + {8'h00, convCode};
    // averaged result keeps 20 bits: sum scaled to 2^(f) samples then 4 extra bits
    wire logic [23:0] avgFull = (accNext << 4) >> avgFactor_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinMode_r   <= adc_ctrl_pkg::PIN_MODE_RST;
            direction_r <= 8'h00;
            driveType_r <= 8'h00;
            outLevels_r <= 8'h00;
            seqEn_r     <= adc_ctrl_pkg::SEQ_EN_RST;
            refEn_r     <= 1'b0;
            range_r     <= 1'b0;
            oscSel_r    <= 1'b0;
            clkDiv_r    <= adc_ctrl_pkg::DIV_RST;
            avgFactor_r <= 3'h0;
            seqMode_r   <= 2'h0;
            manualCh_r  <= 3'h0;
        end else if (req.wr) begin
            unique case (req.addr)
                adc_ctrl_pkg::REG_GENERAL: begin
                    refEn_r <= req.wdata[adc_ctrl_pkg::GEN_REF_BIT];
                    range_r <= req.wdata[adc_ctrl_pkg::GEN_RANGE_BIT];
                end
                adc_ctrl_pkg::REG_AVERAGING:   avgFactor_r <= req.wdata[2:0];
                adc_ctrl_pkg::REG_TIMING: begin
                    clkDiv_r <= req.wdata[adc_ctrl_pkg::TIM_DIV_LSB +: 4];
                    oscSel_r <= req.wdata[adc_ctrl_pkg::TIM_OSC_BIT];
                end
                adc_ctrl_pkg::REG_PIN_MODE:    pinMode_r   <= req.wdata[7:0];
                adc_ctrl_pkg::REG_DIRECTION:   direction_r <= req.wdata[7:0];
                adc_ctrl_pkg::REG_DRIVE_TYPE:  driveType_r <= req.wdata[7:0];
                adc_ctrl_pkg::REG_OUT_LEVELS:  outLevels_r <= req.wdata[7:0];
                adc_ctrl_pkg::REG_SEQ_ENABLES: seqEn_r     <= req.wdata[7:0];
                adc_ctrl_pkg::REG_SEQ_MODE:    seqMode_r   <= req.wdata[1:0];
                adc_ctrl_pkg::REG_CHANNEL:     manualCh_r  <= req.wdata[2:0];
                default: ;
            endcase
        end
    end

    // digital input levels sampled each cycle; analog or output pins read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) inLevels_r <= 8'h00;
        else       inLevels_r <= pinIn & pinMode_r & ~direction_r;
    end

    // pin drive: open-drain only pulls low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinOut[i] = outLevels_r[i];
            pinOe[i]  = pinMode_r[i] && direction_r[i]
                        && (driveType_r[i] || !outLevels_r[i]);
        end
    end
    assign analogSelect  = ~pinMode_r;
    assign internalRefOn = refEn_r;
    assign doubleSpan    = range_r;

    // conversion and calibration sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= IDLE;
            phaseCnt_r  <= 16'h0;
            sampleCnt_r <= 8'h0;
            accum_r     <= 24'h0;
            result_r    <= 20'h0;
            curCh_r     <= 3'h0;
            waitCnt_r   <= 32'h0;
            cal_r       <= 1'b0;
            done_r      <= 1'b0;
        end else begin
            if (req.rd && req.addr == adc_ctrl_pkg::REG_RESULT) done_r <= 1'b0;
            unique case (state_r)
                IDLE: begin
                    if (calReq) begin
                        cal_r      <= 1'b1;
                        phaseCnt_r <= 16'h0;
                        state_r    <= CALIBRATE;
                    end else if (startReq) begin
                        curCh_r     <= autonomous ? next_enabled(3'h7, seqEn_r) : manualCh_r;
                        phaseCnt_r  <= 16'h0;
                        sampleCnt_r <= 8'h0;
                        accum_r     <= 24'h0;
                        state_r     <= CONVERT;
                    end
                end
                CONVERT: begin
                    phaseCnt_r <= phaseCnt_r + 16'h1;
                    if (convEnd) begin
                        waitCnt_r <= 32'h0;
                        if (lastSample) begin
                            result_r    <= avgOn ? avgFull[19:0] : {4'h0, convCode};
                            done_r      <= 1'b1;
                            accum_r     <= 24'h0;
                            sampleCnt_r <= 8'h0;
                            if (autonomous && seqEn_r != 8'h00) begin
                                curCh_r <= next_enabled(curCh_r, seqEn_r);
                                state_r <= WAIT_NEXT;
                            end else begin
                                state_r <= IDLE;
                            end
                        end else begin
                            accum_r     <= accNext;
                            sampleCnt_r <= sampleCnt_r + 8'h1;
                            state_r     <= WAIT_NEXT;
                        end
                    end
                end
                WAIT_NEXT: begin
                    waitCnt_r <= waitCnt_r + 32'h1;
                    if (waitCnt_r + 32'(adc_ctrl_pkg::CONV_CYC) + 32'h1 >= cycleCyc) begin
                        phaseCnt_r <= 16'h0;
                        state_r    <= CONVERT;
                    end
                end
                CALIBRATE: begin
                    phaseCnt_r <= phaseCnt_r + 16'h1;
                    if (phaseCnt_r == 16'(adc_ctrl_pkg::CAL_CYC - 1)) begin
                        cal_r   <= 1'b0;
                        state_r <= IDLE;
                    end
                end
            endcase
        end
    end

    assign convStart   = (state_r == CONVERT) && phaseCnt_r == 16'h0;
    assign convChannel = curCh_r;
    assign acquiring   = state_r == IDLE || state_r == WAIT_NEXT;
    assign calibrating = cal_r;

    // register read, data in the cycle after the strobe
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        unique case (req.addr)
            adc_ctrl_pkg::REG_STATUS: begin
                rdMux[adc_ctrl_pkg::STAT_BUSY_BIT] = state_r != IDLE;
                rdMux[adc_ctrl_pkg::STAT_DONE_BIT] = done_r;
            end
            adc_ctrl_pkg::REG_GENERAL: begin
                rdMux[adc_ctrl_pkg::GEN_REF_BIT]   = refEn_r;
                rdMux[adc_ctrl_pkg::GEN_CAL_BIT]   = cal_r;
                rdMux[adc_ctrl_pkg::GEN_RANGE_BIT] = range_r;
            end
            adc_ctrl_pkg::REG_AVERAGING:   rdMux[2:0] = avgFactor_r;
            adc_ctrl_pkg::REG_TIMING:      rdMux[4:0] = {oscSel_r, clkDiv_r};
            adc_ctrl_pkg::REG_PIN_MODE:    rdMux[7:0] = pinMode_r;
            adc_ctrl_pkg::REG_DIRECTION:   rdMux[7:0] = direction_r;
            adc_ctrl_pkg::REG_DRIVE_TYPE:  rdMux[7:0] = driveType_r;
            adc_ctrl_pkg::REG_OUT_LEVELS:  rdMux[7:0] = outLevels_r;
            adc_ctrl_pkg::REG_IN_LEVELS:   rdMux[7:0] = inLevels_r;
            adc_ctrl_pkg::REG_SEQ_ENABLES: rdMux[7:0] = seqEn_r;
            adc_ctrl_pkg::REG_SEQ_MODE:    rdMux[1:0] = seqMode_r;
            adc_ctrl_pkg::REG_CHANNEL:     rdMux[2:0] = manualCh_r;
            adc_ctrl_pkg::REG_RESULT:      rdMux[19:0] = result_r;
            default:                       rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)       rdata_r <= 32'h0;
        else if (req.rd) rdata_r <= rdMux;
        else             rdata_r <= 32'h0;
    end
    assign regRdata = rdata_r;
endmodule : adc_channel_avg_control

// >>> testbench/adc_channel_avg_control_properties.sv
// port-level checks for the converter control block
`timescale 1ns/1ps
module adc_channel_avg_control_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // register port
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    // pins and core
    input wire logic [7:0]  pinOut,
    input wire logic [7:0]  pinOe,
    input wire logic [7:0]  analogSelect,
    input wire logic        convStart,
    input wire logic        acquiring,
    input wire logic        calibrating,
    input wire logic        internalRefOn,
    input wire logic        doubleSpan
);
    localparam int CONV_LO = adc_ctrl_pkg::CONV_CYC - 10;
    localparam int CONV_HI = adc_ctrl_pkg::CONV_CYC - 6;
    localparam int CAL_LO  = adc_ctrl_pkg::CAL_CYC - 2;
    localparam int CAL_HI  = adc_ctrl_pkg::CAL_CYC + 2;
    logic [10:0] calCnt_r;
    logic [1:0]  relCnt_r;
    wire genWr = regWr && regAddr == adc_ctrl_pkg::REG_GENERAL;
    wire modeWr = regWr && regAddr == adc_ctrl_pkg::REG_PIN_MODE;
    wire dirWr = regWr && regAddr == adc_ctrl_pkg::REG_DIRECTION;
    wire outWr = regWr && regAddr == adc_ctrl_pkg::REG_OUT_LEVELS;
    wire inRd = regRd && regAddr == adc_ctrl_pkg::REG_IN_LEVELS;
    // reset copy inside lags two edges, so the first edge still shows reset values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            calCnt_r <= '0;
            relCnt_r <= '0;
        end else begin
            calCnt_r <= calibrating ? calCnt_r + 11'h1 : 11'h0;
            relCnt_r <= (relCnt_r == 2'h2) ? relCnt_r : relCnt_r + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_convert;
        !acquiring [*8] ##[CONV_LO:CONV_HI] acquiring;
    endsequence
    a_reset_state: assert property (relCnt_r == 2'h0 |-> analogSelect == 8'hff
        && !internalRefOn && !doubleSpan) else $error("state after reset wrong");
    a_pin_mode: assert property (modeWr |=> analogSelect == ~$past(regWdata[7:0]))
        else $error("pin mode not applied");
    a_dir_inputs: assert property (dirWr |=> (pinOe & ~$past(regWdata[7:0])) == 8'h00)
        else $error("input channel driven");
    a_in_levels: assert property (inRd |=> (regRdata[7:0] & $past(analogSelect)) == 8'h00)
        else $error("analog channel level read");
    a_out_level: assert property (outWr |=> pinOut == $past(regWdata[7:0]))
        else $error("output level not applied");
    a_ref_enable: assert property (genWr |=> internalRefOn == $past(regWdata[7]))
        else $error("reference enable wrong");
    a_span_select: assert property (genWr |=> doubleSpan == $past(regWdata[0]))
        else $error("span select wrong");
    a_cal_start: assert property (genWr && regWdata[1] && acquiring && !calibrating
        |=> calibrating) else $error("calibration not started");
    a_cal_length: assert property ($fell(calibrating) |-> calCnt_r >= CAL_LO
        && calCnt_r <= CAL_HI) else $error("calibration length wrong");
    a_conv_timing: assert property (convStart |=> s_convert)
        else $error("acquisition not entered after conversion");
endmodule : adc_channel_avg_control_properties

bind adc_channel_avg_control adc_channel_avg_control_properties
    adc_channel_avg_control_properties_inst (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pinOut(pinOut), .pinOe(pinOe), .analogSelect(analogSelect), .convStart(convStart),
    .acquiring(acquiring), .calibrating(calibrating), .internalRefOn(internalRefOn),
    .doubleSpan(doubleSpan));

// >>> testbench/adc_core_model.sv
// analog core and pin surroundings facing the control block
`timescale 1ns/1ps
module adc_core_model (
    // clock
    input  wire logic        clk,
    // from the block
    input  wire logic        convStart,
    input  wire logic        doubleSpan,
    input  wire logic [7:0]  pinOut,
    input  wire logic [7:0]  pinOe,
    // from the bench, level in single-span steps
    input  wire logic [16:0] inputLevel,
    input  wire logic [7:0]  extLevel,
    // to the block
    output logic      [15:0] convCode,
    output logic      [7:0]  pinIn
);
    logic [6:0]  busyCnt_r = 7'h00;
    logic [15:0] code_r = 16'h0000;
    wire  [16:0] scaled = doubleSpan ? inputLevel >> 1 : inputLevel;
    wire  [15:0] sat = scaled[16] ? 16'hffff : scaled[15:0];
    always_ff @(posedge clk) begin
        if (convStart) begin
            busyCnt_r <= 7'h50;
            code_r <= sat;
        end else if (busyCnt_r != 7'h00) begin
            busyCnt_r <= busyCnt_r - 7'h01;
        end else begin
            // no stale code outside a conversion
            code_r <= ~code_r;
        end
    end
    assign convCode = code_r;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : adc_core_model

// >>> testbench/adc_channel_avg_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_channel_avg_control_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [16:0] inputLevel = 17'h0;
    logic [7:0] extLevel = 8'ha5;
    wire [31:0] regRdata;
    wire [7:0] pinIn, pinOut, pinOe, analogSelect;
    wire [15:0] convCode;
    wire [2:0] convChannel;
    wire convStart, acquiring, calibrating, internalRefOn, doubleSpan;
    int badCount = 0, checked = 0, cyc = 0, starts = 0, lastAt = 0, gap = 0;
    logic [2:0] chans[$];
    logic [31:0] d;
    always #20 clk = ~clk;
    adc_channel_avg_control adc_channel_avg_control_inst (.clk(clk), .arst_n(arst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .analogSelect(analogSelect), .convStart(convStart), .convChannel(convChannel),
        .acquiring(acquiring), .calibrating(calibrating), .convCode(convCode),
        .internalRefOn(internalRefOn), .doubleSpan(doubleSpan));
    adc_core_model adc_core_model_inst (.clk(clk), .convStart(convStart),
        .doubleSpan(doubleSpan), .pinOut(pinOut), .pinOe(pinOe), .inputLevel(inputLevel),
        .extLevel(extLevel), .convCode(convCode), .pinIn(pinIn));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convStart) begin
            starts <= starts + 1;
            gap <= cyc - lastAt;
            lastAt <= cyc;
            chans.push_back(convChannel);
        end
        // whole run, the 128-sample average its longest part, stays well under this
        if (cyc > 60000) begin
            badCount++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // strobe is lowered then an idle edge passes, so calls never collide
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        // data stand only in this cycle; take them mid-cycle, clear of the edges
        @(negedge clk);
        v = regRdata;
        @(posedge clk);
    endtask : rd
    task automatic wait_done();
        d = 32'h0;
        for (int i = 0; i < 20000 && d[1] !== 1'b1; i++) rd(adc_ctrl_pkg::REG_STATUS, d);
        chk(d[1], 1'b1);
    endtask : wait_done
    task automatic test_reset();
        chk(analogSelect, 8'hff);
        chk(internalRefOn, 1'b0);
        chk(doubleSpan, 1'b0);
        rd(adc_ctrl_pkg::REG_GENERAL, d);
        chk(d, 32'h0);
        rd(4'hf, d);
        chk(d, 32'h0);
    endtask : test_reset
    task automatic test_pins();
        wr(adc_ctrl_pkg::REG_PIN_MODE, 32'hf0);
        wr(adc_ctrl_pkg::REG_DIRECTION, 32'h30);
        wr(adc_ctrl_pkg::REG_DRIVE_TYPE, 32'h10);
        wr(adc_ctrl_pkg::REG_OUT_LEVELS, 32'h30);
        chk(analogSelect, 8'h0f);
        chk(pinOe, 8'h10);
        chk(pinOut & 8'h30, 8'h30);
        wr(adc_ctrl_pkg::REG_OUT_LEVELS, 32'h00);
        chk(pinOe, 8'h30);
        rd(adc_ctrl_pkg::REG_IN_LEVELS, d);
        chk(d, 32'h80);
        wr(adc_ctrl_pkg::REG_PIN_MODE, 32'h00);
        chk(analogSelect, 8'hff);
    endtask : test_pins
    task automatic test_ref_cal();
        int t0;
        wr(adc_ctrl_pkg::REG_GENERAL, 32'h81);
        chk({internalRefOn, doubleSpan}, 2'b11);
        wr(adc_ctrl_pkg::REG_GENERAL, 32'h02);
        t0 = cyc;
        chk({calibrating, internalRefOn, doubleSpan}, 3'b100);
        d = 32'h2;
        for (int i = 0; i < 2000 && d[1] !== 1'b0; i++) rd(adc_ctrl_pkg::REG_GENERAL, d);
        chk(d[1], 1'b0);
        chk(cyc - t0 >= adc_ctrl_pkg::CAL_CYC, 1'b1);
    endtask : test_ref_cal
    task automatic test_single();
        logic [16:0] lvl[4] = '{17'h0, 17'h08000, 17'h1ffff, 17'h10000};
        logic [15:0] exp[4] = '{16'h0, 16'h8000, 16'hffff, 16'h8000};
        int s0;
        wr(adc_ctrl_pkg::REG_AVERAGING, 32'h0);
        wr(adc_ctrl_pkg::REG_CHANNEL, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(adc_ctrl_pkg::REG_GENERAL, (i == 3) ? 32'h1 : 32'h0);
            inputLevel <= lvl[i];
            s0 = starts;
            wr(adc_ctrl_pkg::REG_START, 32'h1);
            chk(convChannel, 3'h3);
            wait_done();
            rd(adc_ctrl_pkg::REG_RESULT, d);
            chk(d, {16'h0, exp[i]});
            chk(starts - s0, 1);
        end
    endtask : test_single
    task automatic test_avg();
        int s0;
        wr(adc_ctrl_pkg::REG_GENERAL, 32'h0);
        wr(adc_ctrl_pkg::REG_TIMING, 32'h04);
        for (int n = 1; n < 8; n++) begin
            inputLevel <= 17'h01230 + 17'(n);
            s0 = starts;
            wr(adc_ctrl_pkg::REG_AVERAGING, 32'(n));
            wr(adc_ctrl_pkg::REG_START, 32'h1);
            if (n == 2) begin
                repeat (150) @(posedge clk);
                rd(adc_ctrl_pkg::REG_RESULT, d);
                chk(d, 32'h12310);
            end
            wait_done();
            chk(starts - s0, 1 << n);
            chk(gap, 100);
            rd(adc_ctrl_pkg::REG_RESULT, d);
            chk(d, {12'h0, 16'h1230 + 16'(n), 4'h0});
        end
        // slow oscillator, divider 0000b: 32 us between internal starts
        wr(adc_ctrl_pkg::REG_TIMING, 32'h10);
        wr(adc_ctrl_pkg::REG_AVERAGING, 32'h1);
        wr(adc_ctrl_pkg::REG_START, 32'h1);
        wait_done();
        chk(gap, 800);
        rd(adc_ctrl_pkg::REG_RESULT, d);
        chk(d, 32'h12370);
    endtask : test_avg
    task automatic test_autonomous();
        wr(adc_ctrl_pkg::REG_AVERAGING, 32'h1);
        wr(adc_ctrl_pkg::REG_SEQ_ENABLES, 32'h05);
        chans.delete();
        wr(adc_ctrl_pkg::REG_SEQ_MODE, 32'h2);
        wr(adc_ctrl_pkg::REG_START, 32'h1);
        for (int i = 0; i < 5000 && chans.size() < 6; i++) @(posedge clk);
        chk(chans.size() >= 6, 1'b1);
        for (int i = 0; i < 6 && i < chans.size(); i++) chk(chans[i], (i / 2) % 2 ? 2 : 0);
    endtask : test_autonomous
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_pins();
        test_ref_cal();
        test_single();
        test_avg();
        test_autonomous();
        report_and_stop();
    end
endmodule : adc_channel_avg_control_tb_top
